// File: ccd_decoder.sv
// Command decoder of a five-counter timing controller.
// Assumes command writes, counter status and mode configuration come from
// logic on sys_clk_i; gate levels come from pins and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "ccd_regs.svh"

module ccd_decoder #(
  parameter int NUM_CTR = 5
) (
  // Clock, reset, enable
  input  wire  logic                            sys_clk_i,
  input  wire  logic                            rst_b_i,
  input  wire  logic                            clk_en_i,
  // Control port command write
  input  wire  logic                            cmd_wr_i,
  input  wire  logic [`CCD_CMD_W-1:0]           cmd_data_i,
  // Per-counter status, configuration and gate pins
  input  wire  ccd_pkg::ccd_stat_t [NUM_CTR-1:0] ctr_stat_i,
  input  wire  ccd_pkg::ccd_cfg_t  [NUM_CTR-1:0] ctr_cfg_i,
  input  wire  logic [NUM_CTR-1:0]              gate_pin_i,
  // Per-counter control
  output       ccd_pkg::ccd_ctl_t  [NUM_CTR-1:0] ctr_ctl_o,
  output       logic [NUM_CTR-1:0]              count_en_o,
  // Device-wide state
  output       ccd_pkg::ccd_mm_t                mm_o,
  output       ccd_pkg::ccd_dptr_t              dptr_o,
  output       logic                            dptr_load_o,
  output       logic                            prefetch_en_o,
  output       logic                            master_reset_o
);

  // Elaboration check: the select field holds at most five counters
  if (NUM_CTR < 1 || NUM_CTR > 5) begin : g_bad_num
    $error("NUM_CTR must lie between 1 and 5");
  end

  logic [`CCD_CMD_W-1:0] command_entry_r;
  logic                  cmd_pend_r;
  ccd_pkg::ccd_kind_t    kind;
  logic [2:0]            opc;
  logic [1:0]            sub;
  logic [2:0]            num;
  logic                  num_ok;
  logic                  do_mrst;

  // Command register capture; one byte is one command
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      command_entry_r <= `CCD_CMD_RST;
      cmd_pend_r      <= 1'b0;
    end else if (clk_en_i) begin
      cmd_pend_r <= cmd_wr_i;
      if (cmd_wr_i) begin
        command_entry_r <= cmd_data_i;
      end
    end
  end

  assign opc    = command_entry_r[`CCD_OPC_MSB:`CCD_OPC_LSB];
  assign sub    = command_entry_r[`CCD_SUB_MSB:`CCD_SUB_LSB];
  assign num    = command_entry_r[`CCD_NUM_MSB:`CCD_NUM_LSB];
  assign num_ok = (num >= `CCD_NUM_MIN) && (num <= `CCD_NUM_MAX);

  // Decode the captured byte; every unused code becomes a no-operation
  always_comb begin
    kind = ccd_pkg::CCD_NOP;
    if (cmd_pend_r) begin
      case (opc)
        `CCD_OPC_DPTR: begin
          if (num != `CCD_GRP_BAD0 && num != `CCD_GRP_BAD1) begin
            kind = ccd_pkg::CCD_DPTR;
          end
        end
        `CCD_OPC_ARM:    kind = ccd_pkg::CCD_ARM;
        `CCD_OPC_LOAD:   kind = ccd_pkg::CCD_LOAD;
        `CCD_OPC_LDARM:  kind = ccd_pkg::CCD_LDARM;
        `CCD_OPC_DSAVE:  kind = ccd_pkg::CCD_DSAVE;
        `CCD_OPC_SAVE:   kind = ccd_pkg::CCD_SAVE;
        `CCD_OPC_DISARM: kind = ccd_pkg::CCD_DISARM;
        `CCD_OPC_SINGLE: begin
          case (sub)
            `CCD_SUB_CLR, `CCD_SUB_SET: begin
              if (num_ok) begin
                kind = (sub == `CCD_SUB_SET) ? ccd_pkg::CCD_TOGSET
                                             : ccd_pkg::CCD_TOGCLR;
              end else begin
                kind = (sub == `CCD_SUB_SET) ? ccd_pkg::CCD_MMSET
                                             : ccd_pkg::CCD_MMCLR;
              end
            end
            `CCD_SUB_STEP: begin
              if (num_ok) begin
                kind = ccd_pkg::CCD_STEP;
              end
            end
            `CCD_SUB_MISC: begin
              case (num)
                `CCD_N_PF_EN:  kind = ccd_pkg::CCD_PFEN;
                `CCD_N_PF_DIS: kind = ccd_pkg::CCD_PFDIS;
                `CCD_N_MRST:   kind = ccd_pkg::CCD_MRST;
                default:       kind = ccd_pkg::CCD_NOP;
              endcase
            end
            default: kind = ccd_pkg::CCD_NOP;
          endcase
        end
        default: kind = ccd_pkg::CCD_NOP;
      endcase
    end
  end

  assign do_mrst = (kind == ccd_pkg::CCD_MRST);

  // Master mode bits: one bit changes, the others hold
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mm_o <= '0;
    end else if (clk_en_i) begin
      if (do_mrst) begin
        mm_o <= '0;
      end else if (kind == ccd_pkg::CCD_MMSET || kind == ccd_pkg::CCD_MMCLR) begin
        case (num)
          `CCD_N_SEQ:  mm_o.sequencing_disable_bit <= (kind == ccd_pkg::CCD_MMSET);
          `CCD_N_FREQUENCY_OUTPUT: mm_o.freq_out_gate_off_bit  <= (kind == ccd_pkg::CCD_MMSET);
          `CCD_N_WIDE: mm_o.wide_bus_bit           <= (kind == ccd_pkg::CCD_MMSET);
          default:     mm_o <= mm_o;
        endcase
      end
    end
  end

  // Data pointer element and group fields; byte pointer is set
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      dptr_o      <= '0;
      dptr_load_o <= 1'b0;
    end else if (clk_en_i) begin
      dptr_load_o <= (kind == ccd_pkg::CCD_DPTR);
      if (do_mrst) begin
        dptr_o <= '0;
      end else if (kind == ccd_pkg::CCD_DPTR) begin
        dptr_o.element  <= command_entry_r[`CCD_ELEM_MSB:`CCD_ELEM_LSB];
        dptr_o.group    <= num;
        dptr_o.byte_ptr <= 1'b1;
      end
    end
  end

  // Write prefetch control and master reset pulse
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      prefetch_en_o  <= 1'b0;
      master_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      master_reset_o <= do_mrst;
      if (do_mrst) begin
        prefetch_en_o <= 1'b0;
      end else if (kind == ccd_pkg::CCD_PFEN) begin
        prefetch_en_o <= 1'b1;
      end else if (kind == ccd_pkg::CCD_PFDIS) begin
        prefetch_en_o <= 1'b0;
      end
    end
  end

  // Per-counter arm, reload selection and command pulses
  for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
    logic      sel_hit;
    logic      one_hit;
    logic      gate_s1_r;
    logic      gate_s2_r;
    logic      is_load;
    logic      is_ldarm;
    logic      is_disarm;
    logic      is_save;
    logic      is_arm;
    logic      src_hold;
    ccd_pkg::ccd_stat_t st;
    ccd_pkg::ccd_cfg_t  cf;
    // Control state and command pulses of this counter
    logic      armed_r;
    logic      pend_r;
    logic      selh_r;
    logic      load_r;
    logic      lhold_r;
    logic      ltc_r;
    logic      save_r;
    logic      step_r;
    logic      tset_r;
    logic      tclr_r;
    logic      any_load;

    assign st      = ctr_stat_i[i];
    assign cf      = ctr_cfg_i[i];
    assign sel_hit = command_entry_r[i];
    assign one_hit = (num == 3'(i + 1));

    assign is_arm    = sel_hit && kind == ccd_pkg::CCD_ARM;
    assign is_load   = sel_hit && kind == ccd_pkg::CCD_LOAD;
    assign is_ldarm  = sel_hit && kind == ccd_pkg::CCD_LDARM;
    assign is_disarm = sel_hit && (kind == ccd_pkg::CCD_DISARM ||
                                   kind == ccd_pkg::CCD_DSAVE);
    assign is_save   = sel_hit && (kind == ccd_pkg::CCD_SAVE ||
                                   kind == ccd_pkg::CCD_DSAVE);

    // Gate pin synchroniser
    always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
        gate_s1_r <= 1'b0;
        gate_s2_r <= 1'b0;
      end else if (clk_en_i) begin
        gate_s1_r <= gate_pin_i[i];
        gate_s2_r <= gate_s1_r;
      end
    end

    // Either kind of load command for this counter
    assign any_load = is_load || is_ldarm;

    // Load source: gate level, upcoming tc source, or load register
    always_comb begin
      if (cf.gate_reload) begin
        src_hold = gate_s2_r;
      end else if (armed_r && cf.alt_reload) begin
        src_hold = selh_r;
      end else begin
        src_hold = 1'b0;
      end
    end

    // Arm state with disarm held off during terminal count
    always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
        armed_r <= 1'b0;
        pend_r  <= 1'b0;
      end else if (clk_en_i) begin
        if (do_mrst) begin
          armed_r <= 1'b0;
          pend_r  <= 1'b0;
        end else if (is_arm || is_ldarm) begin
          armed_r <= 1'b1;
          pend_r  <= 1'b0;
        end else if (is_disarm) begin
          if (st.at_tc) begin
            pend_r <= 1'b1;
          end else begin
            armed_r <= 1'b0;
          end
        end else if (pend_r && !st.at_tc) begin
          armed_r <= 1'b0;
          pend_r  <= 1'b0;
        end
      end
    end

    // Reload alternation selector; an arm wins over a toggle in one cycle
    always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
        selh_r <= 1'b1;
      end else if (clk_en_i) begin
        if (do_mrst) begin
          selh_r <= 1'b1;
        end else if (is_arm || is_ldarm) begin
          selh_r <= 1'b1;
        end else if (cf.alt_reload &&
                     (st.tc_event || (is_load && st.next_tc && !st.at_tc))) begin
          selh_r <= !selh_r;
        end
      end
    end

    // One-cycle command pulses to the counter core
    always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
        load_r  <= 1'b0;
        lhold_r <= 1'b0;
        ltc_r   <= 1'b0;
        save_r  <= 1'b0;
        step_r  <= 1'b0;
        tset_r  <= 1'b0;
        tclr_r  <= 1'b0;
      end else if (clk_en_i) begin
        load_r  <= any_load;
        lhold_r <= any_load && src_hold;
        ltc_r   <= any_load && st.next_tc && !st.at_tc;
        save_r  <= is_save;
        step_r  <= one_hit && kind == ccd_pkg::CCD_STEP;
        tset_r  <= one_hit && kind == ccd_pkg::CCD_TOGSET;
        tclr_r  <= one_hit && kind == ccd_pkg::CCD_TOGCLR;
      end
    end

    // Control word to the core; one writer per counter slice
    assign ctr_ctl_o[i] = '{armed:       armed_r,
                            disarm_pend: pend_r,
                            sel_hold:    selh_r,
                            load:        load_r,
                            load_hold:   lhold_r,
                            load_to_tc:  ltc_r,
                            save:        save_r,
                            step:        step_r,
                            tog_set:     tset_r,
                            tog_clr:     tclr_r};

    // Counting needs arm and the gating qualification
    assign count_en_o[i] = armed_r && st.gate_ok;
  end

endmodule // ccd_decoder
`default_nettype wire

// File: ccd_decoder_monitor.sv
// Assertion checker for the counter command decoder, bound to its ports.
// Assumes one clock; a command shows its effect two enabled edges later.
`timescale 1ns/100ps
`default_nettype none
`include "ccd_regs.svh"
module ccd_decoder_chk #(
  parameter int NUM_CTR = 5
) (
  // Clock, reset, enable
  input wire logic                             sys_clk_i,
  input wire logic                             rst_b_i,
  input wire logic                             clk_en_i,
  // Command write
  input wire logic                             cmd_wr_i,
  input wire logic [`CCD_CMD_W-1:0]            cmd_data_i,
  // Counter side
  input wire ccd_pkg::ccd_stat_t [NUM_CTR-1:0] ctr_stat_i,
  input wire ccd_pkg::ccd_cfg_t  [NUM_CTR-1:0] ctr_cfg_i,
  input wire logic [NUM_CTR-1:0]               gate_pin_i,
  input wire ccd_pkg::ccd_ctl_t  [NUM_CTR-1:0] ctr_ctl_o,
  input wire logic [NUM_CTR-1:0]               count_en_o,
  // Device-wide state
  input wire ccd_pkg::ccd_mm_t                 mm_o,
  input wire ccd_pkg::ccd_dptr_t               dptr_o,
  input wire logic                             dptr_load_o,
  input wire logic                             prefetch_en_o,
  input wire logic                             master_reset_o
);
  logic [NUM_CTR-1:0] arm_v, pend_v, selh_v, load_v, step_v, tset_v, gok_v;
  logic [7:0]         d1_r, d2_r;
  // Per-counter fields gathered into vectors
  always_comb begin
    for (int i = 0; i < NUM_CTR; i++) begin
      arm_v[i]  = ctr_ctl_o[i].armed;
      pend_v[i] = ctr_ctl_o[i].disarm_pend;
      selh_v[i] = ctr_ctl_o[i].sel_hold;
      load_v[i] = ctr_ctl_o[i].load;
      step_v[i] = ctr_ctl_o[i].step;
      tset_v[i] = ctr_ctl_o[i].tog_set;
      gok_v[i]  = ctr_stat_i[i].gate_ok;
    end
  end
  // Command byte two edges back
  always_ff @(posedge sys_clk_i) begin
    d1_r <= cmd_data_i;
    d2_r <= d1_r;
  end
  // One-hot of a counter number, zero when out of range
  function automatic logic [NUM_CTR-1:0] one(input logic [2:0] n);
    one = '0;
    if (n >= 3'h1 && n <= 3'h5) one[n-3'h1] = 1'b1;
  endfunction
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Byte taken, then two enabled edges
  sequence s_cmd(logic [7:0] m, logic [7:0] v);
    clk_en_i && cmd_wr_i && ((cmd_data_i & m) == v) ##1 clk_en_i ##1 clk_en_i;
  endsequence
  property p_arm;
    s_cmd(8'he0, 8'h20) |-> ((arm_v & selh_v & d2_r[4:0]) == d2_r[4:0])
      && ((~arm_v & $past(arm_v) & ~$past(pend_v) & ~d2_r[4:0]) == '0);
  endproperty
  a_arm: assert property (p_arm) else $error("arm select wrong");
  property p_load;
    s_cmd(8'he0, 8'h40) |-> load_v == d2_r[4:0];
  endproperty
  a_load: assert property (p_load) else $error("load select wrong");
  property p_dis;
    s_cmd(8'he0, 8'hc0) |-> (arm_v & ~pend_v & d2_r[4:0]) == '0;
  endproperty
  a_dis: assert property (p_dis) else $error("disarm missed");
  property p_step;
    s_cmd(8'hf8, 8'hf0) |-> step_v == one(d2_r[2:0]);
  endproperty
  a_step: assert property (p_step) else $error("step target wrong");
  property p_tset;
    s_cmd(8'hf8, 8'he8) |-> tset_v == one(d2_r[2:0]);
  endproperty
  a_tset: assert property (p_tset) else $error("toggle set wrong");
  property p_mm;
    s_cmd(8'hff, 8'he8) |-> mm_o.sequencing_disable_bit && $stable(mm_o.wide_bus_bit);
  endproperty
  a_mm: assert property (p_mm) else $error("mode bit set wrong");
  property p_pf;
    s_cmd(8'hfe, 8'hf8) |-> prefetch_en_o == !d2_r[0];
  endproperty
  a_pf: assert property (p_pf) else $error("prefetch wrong");
  property p_rsv;
    s_cmd(8'hf8, 8'hf8) |-> (d2_r inside {8'hf8, 8'hf9, 8'hff})
      || (!master_reset_o && $stable(prefetch_en_o));
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code acted");
  property p_dptr;
    s_cmd(8'he0, 8'h00) |-> dptr_load_o == !(d2_r[2:0] inside {3'h0, 3'h6});
  endproperty
  a_dptr: assert property (p_dptr) else $error("pointer load wrong");
  property p_cnt;
    count_en_o == (arm_v & gok_v);
  endproperty
  a_cnt: assert property (p_cnt) else $error("count enable wrong");
  property p_hold;
    pend_v[0] && ctr_stat_i[0].at_tc |=> arm_v[0];
  endproperty
  a_hold: assert property (p_hold) else $error("disarmed in tc");
endmodule // ccd_decoder_chk
bind ccd_decoder ccd_decoder_chk #(.NUM_CTR(NUM_CTR)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i), .cmd_wr_i(cmd_wr_i),
  .cmd_data_i(cmd_data_i), .ctr_stat_i(ctr_stat_i), .ctr_cfg_i(ctr_cfg_i),
  .gate_pin_i(gate_pin_i), .ctr_ctl_o(ctr_ctl_o), .count_en_o(count_en_o), .mm_o(mm_o),
  .dptr_o(dptr_o), .dptr_load_o(dptr_load_o), .prefetch_en_o(prefetch_en_o),
  .master_reset_o(master_reset_o));
`default_nettype wire

// File: ccd_host.sv
// Host model: writes command bytes to the control port.
// Assumes the decoder takes a byte at a rising edge with its strobe high.
`timescale 1ns/100ps
`default_nettype none
module ccd_host (
  // Clock
  input  wire logic       sys_clk_i,
  // Control port write
  output var  logic       cmd_wr_o,
  output var  logic [7:0] cmd_data_o
);
  // Idle port at start
  initial begin
    cmd_wr_o = 1'b0;
    cmd_data_o = 8'h00;
  end
  // One byte per strobe; released data is inverted, never left standing
  // Reserved codes are sent as given, like any other byte
  task automatic send(input logic [7:0] b);
    @(negedge sys_clk_i);
    cmd_wr_o = 1'b1;
    cmd_data_o = b;
    @(negedge sys_clk_i);
    cmd_wr_o = 1'b0;
    cmd_data_o = ~b;
  endtask
endmodule // ccd_host
`default_nettype wire

// File: ccd_pkg.sv
// Types of the counter command decoder: command kinds and carriers.
// Assumes the counter core and gating logic sit outside the decoder.
package ccd_pkg;
  typedef enum {
    CCD_NOP, CCD_DPTR, CCD_ARM, CCD_LOAD, CCD_LDARM, CCD_DSAVE, CCD_SAVE,
    CCD_DISARM, CCD_TOGCLR, CCD_TOGSET, CCD_STEP, CCD_MMSET, CCD_MMCLR,
    CCD_PFEN, CCD_PFDIS, CCD_MRST
  } ccd_kind_t;
  // Status reported by one counter core
  typedef struct packed {
    logic at_tc;       // Counter sits in terminal count
    logic next_tc;     // Next count reaches terminal count
    logic tc_event;    // Source edge produced terminal count
    logic gate_ok;     // Gating configuration allows counting
  } ccd_stat_t;
  // Mode configuration of one counter
  typedef struct packed {
    logic alt_reload;  // Reload source alternates on each terminal count
    logic gate_reload; // Gate level picks the reload source
  } ccd_cfg_t;
  // Control to one counter core
  typedef struct packed {
    logic armed;
    logic disarm_pend;
    logic sel_hold;    // Upcoming terminal count reloads from hold
    logic load;        // Pulse: transfer into counter
    logic load_hold;   // Source of that transfer is the hold register
    logic load_to_tc;  // Pulse: the transfer drives the counter into tc
    logic save;        // Pulse: counter into hold register
    logic step;        // Pulse: count one in configured direction
    logic tog_set;
    logic tog_clr;
  } ccd_ctl_t;
  // Master mode bits held by the decoder
  typedef struct packed {
    logic sequencing_disable_bit;
    logic wide_bus_bit;
    logic freq_out_gate_off_bit;
  } ccd_mm_t;
  // Data pointer fields
  typedef struct packed {
    logic [1:0] element;
    logic [2:0] group;
    logic       byte_ptr;
  } ccd_dptr_t;
endpackage : ccd_pkg

// File: ccd_regs.svh
// Constants of the counter command decoder: opcode fields and codes.
// Assumes it is included by the decoder and its checker, by its bare name.
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH
`define CCD_CMD_W        8
`define CCD_CMD_RST      8'h00
`define CCD_OPC_MSB      7
`define CCD_OPC_LSB      5
`define CCD_SUB_MSB      4
`define CCD_SUB_LSB      3
`define CCD_NUM_MSB      2
`define CCD_NUM_LSB      0
`define CCD_ELEM_MSB     4
`define CCD_ELEM_LSB     3
`define CCD_OPC_DPTR     3'h0
`define CCD_OPC_ARM      3'h1
`define CCD_OPC_LOAD     3'h2
`define CCD_OPC_LDARM    3'h3
`define CCD_OPC_DSAVE    3'h4
`define CCD_OPC_SAVE     3'h5
`define CCD_OPC_DISARM   3'h6
`define CCD_OPC_SINGLE   3'h7
`define CCD_SUB_CLR      2'h0
`define CCD_SUB_SET      2'h1
`define CCD_SUB_STEP     2'h2
`define CCD_SUB_MISC     2'h3
`define CCD_NUM_MIN      3'h1
`define CCD_NUM_MAX      3'h5
`define CCD_N_SEQ        3'h0
`define CCD_N_FREQUENCY_OUTPUT       3'h6
`define CCD_N_WIDE       3'h7
`define CCD_N_PF_EN      3'h0
`define CCD_N_PF_DIS     3'h1
`define CCD_N_MRST       3'h7
`define CCD_GRP_BAD0     3'h0
`define CCD_GRP_BAD1     3'h6
`endif

// File: ccd_testbench.sv
// Testbench of the counter command decoder, commands sent through ccd_host.
// Assumes counter status, modes and gates are driven here at falling edges.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk_i, rst_b_i, clk_en, cmd_wr, dptr_ld, pf_en, mrst;
  logic [7:0] cmd_data;
  ccd_pkg::ccd_stat_t [4:0] stat;
  ccd_pkg::ccd_cfg_t [4:0] cfg;
  ccd_pkg::ccd_ctl_t [4:0] ctl;
  ccd_pkg::ccd_mm_t mm;
  ccd_pkg::ccd_dptr_t dptr;
  logic [4:0] gate, cnt_en, arm_v, pend_v, selh_v, load_v, lhold_v, ltc_v, save_v, e;
  logic [4:0] step_v, tset_v, tclr_v;
  logic [7:0] ops [3] = '{8'he8, 8'he0, 8'hf0};
  logic [7:0] mm_c [6] = '{8'he8, 8'hee, 8'hef, 8'he0, 8'he6, 8'he7};
  logic [2:0] mm_e [6] = '{3'h4, 3'h5, 3'h7, 3'h3, 3'h2, 3'h0};
  int fail_count = 0;
  int n_compared = 0;
  // Clock of 10 ns
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  ccd_decoder #(.NUM_CTR(5)) dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en), .cmd_wr_i(cmd_wr),
    .cmd_data_i(cmd_data), .ctr_stat_i(stat), .ctr_cfg_i(cfg), .gate_pin_i(gate),
    .ctr_ctl_o(ctl), .count_en_o(cnt_en), .mm_o(mm), .dptr_o(dptr), .dptr_load_o(dptr_ld),
    .prefetch_en_o(pf_en), .master_reset_o(mrst));
  ccd_host host (.sys_clk_i(sys_clk_i), .cmd_wr_o(cmd_wr), .cmd_data_o(cmd_data));
  // Per-counter fields gathered into vectors
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      {arm_v[i], pend_v[i], selh_v[i], load_v[i], lhold_v[i]} = ctl[i][9:5];
      {ltc_v[i], save_v[i], step_v[i], tset_v[i], tclr_v[i]} = ctl[i][4:0];
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // Send a command, then wait until its effect shows
  task automatic cmd(input logic [7:0] b);
    host.send(b);
    @(negedge sys_clk_i);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic final_report();
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    fail_count++;
    final_report();
  end
  // Test sequence
  initial begin
    rst_b_i = 1'b0;
    clk_en = 1'b1;
    stat = {5{4'h1}};
    cfg = '0;
    gate = '0;
    idle(2);
    rst_b_i = 1'b1;
    chk({arm_v, selh_v, cnt_en, mm}, {5'h00, 5'h1f, 5'h00, 3'h0});
    cfg[0].alt_reload = 1'b1;
    cfg[4].alt_reload = 1'b1;
    cmd(8'h25);
    chk({arm_v, selh_v, cnt_en}, {5'h05, 5'h1f, 5'h05});
    stat[2].gate_ok = 1'b0;
    idle(1);
    chk(cnt_en, 5'h01);
    stat[2].gate_ok = 1'b1;
    cmd(8'h22);
    chk(arm_v, 5'h07);
    cmd(8'h5f);
    chk({load_v, lhold_v, ltc_v}, {5'h1f, 5'h01, 5'h00});
    stat[0].next_tc = 1'b1;
    cmd(8'h41);
    chk({load_v, lhold_v, ltc_v}, {5'h01, 5'h01, 5'h01});
    stat[0].next_tc = 1'b0;
    stat[0].at_tc = 1'b1;
    idle(1);
    chk(selh_v, 5'h1e);
    cmd(8'h41);
    chk({load_v, lhold_v, ltc_v}, {5'h01, 5'h00, 5'h00});
    idle(1);
    chk(selh_v, 5'h1e);
    stat[0].at_tc = 1'b0;
    cmd(8'h21);
    chk(selh_v, 5'h1f);
    stat[0].tc_event = 1'b1;
    idle(1);
    stat[0].tc_event = 1'b0;
    idle(1);
    chk(selh_v, 5'h1e);
    cmd(8'h61);
    chk({arm_v, selh_v, load_v}, {5'h07, 5'h1f, 5'h01});
    cfg[1].gate_reload = 1'b1;
    for (int g = 1; g >= 0; g--) begin
      gate = {3'h0, g[0], 1'b0};
      idle(3);
      cmd(8'h42);
      chk(lhold_v, {3'h0, g[0], 1'b0});
    end
    stat[0].at_tc = 1'b1;
    cmd(8'hc3);
    chk({arm_v, pend_v}, {5'h05, 5'h01});
    idle(3);
    chk(arm_v, 5'h05);
    stat[0].at_tc = 1'b0;
    idle(3);
    chk({arm_v, pend_v}, {5'h04, 5'h00});
    cmd(8'hb5);
    chk({save_v, arm_v}, {5'h15, 5'h04});
    cmd(8'h8c);
    chk({save_v, arm_v}, {5'h0c, 5'h00});
    clk_en = 1'b0;
    cmd(8'h28);
    chk({arm_v, save_v}, {5'h00, 5'h0c});
    clk_en = 1'b1;
    for (int n = 0; n < 8; n++)
      for (int k = 0; k < 3; k++) begin
        e = (n >= 1 && n <= 5) ? 5'h01 << (n - 1) : 5'h00;
        cmd(ops[k] | 8'(n));
        chk({tset_v, tclr_v, step_v}, {k == 0 ? e : 5'h0, k == 1 ? e : 5'h0,
            k == 2 ? e : 5'h0});
      end
    foreach (mm_c[i]) begin
      cmd(mm_c[i]);
      chk(mm, mm_e[i]);
    end
    cmd(8'hf8);
    chk({pf_en, mrst}, 2'h2);
    cmd(8'hfa);
    chk({pf_en, mrst, load_v}, 7'h40);
    cmd(8'hf9);
    chk(pf_en, 1'b0);
    cmd(8'h1d);
    chk({dptr_ld, dptr}, 7'h7b);
    cmd(8'h06);
    chk({dptr_ld, dptr}, 7'h3b);
    cmd(8'h3f);
    chk(arm_v, 5'h1f);
    cmd(8'hff);
    chk({mrst, arm_v, pf_en}, 7'h40);
    final_report();
  end
endmodule // testbench
`default_nettype wire
